/* File: verilog/smt_tx.sv */
// Asynchronous multiprocessor-mode serial transmitter with APB registers
//
// Contract
// - Buffer-empty low means load holding into shifter
// - After load set buffer-empty and start frame
// - Buffer-empty interrupt on load when enabled
// - Frame begins with one low start bit
// - Seven or eight data bits, LSB first
// - Multiprocessor bit equals software-written value
// - One or two high stop bits
// - Line held high between frames
// - Buffer-empty sampled when stop bit begins
// - New data at stop: load, continue seamlessly
// - No data at stop: set done, idle
// - Done interrupt on done when enabled
`timescale 1ns/1ns
`default_nettype none
`include "smt_defs.svh"

module smt_tx (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Serial line
	output logic txd,
	// Interrupt requests
	output logic tx_empty_irq,
	output logic tx_done_irq
);

	// Offset decode, shared by the read and write paths
	function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] off);
		reg_hit = (addr == off);
	endfunction

	// Any mapped offset
	function automatic logic reg_mapped(input logic [11:0] addr);
		reg_mapped = reg_hit(addr, `SMT_OFF_HOLD) || reg_hit(addr, `SMT_OFF_STAT) ||
			reg_hit(addr, `SMT_OFF_CTRL) || reg_hit(addr, `SMT_OFF_BAUD);
	endfunction

	// Register state
	logic [7:0] tx_holding_register;
	logic [7:0] next_hold;
	smt_pkg::smt_stat_t serial_status_register; // Empty, done and mp bit
	smt_pkg::smt_stat_t next_stat;
	smt_pkg::smt_ctrl_t serial_control_register; // Enables and frame format
	smt_pkg::smt_ctrl_t next_ctrl;
	logic [15:0] baud_div; // Bit period minus one, in clocks
	logic [15:0] next_baud;
	logic [31:0] next_prdata;

	// Sequencer state
	smt_pkg::smt_state_t st;
	smt_pkg::smt_state_t next_st;
	logic [7:0] tx_shift_register;
	logic [7:0] next_sh;
	logic [2:0] bcnt; // Data bit index
	logic [2:0] next_bcnt;
	logic chain; // Next frame already loaded
	logic next_chain;
	logic next_txd;
	logic load; // Holding register moves into shifter
	logic done_set; // No data waiting at stop time
	logic tick; // End of current bit period
	logic [2:0] last_bit;

	// Bus strobes
	logic wr_acc;
	logic rd_setup;
	assign wr_acc = psel && penable && pwrite;
	assign rd_setup = psel && !penable && !pwrite;

	// Zero-wait slave; unmapped offsets answer with an error
	assign pready = 1'b1;
	assign pslverr = psel && penable && !reg_mapped(paddr);

	assign tx_empty_irq = serial_status_register.empty && serial_control_register.tx_empty_irq_enable;
	assign tx_done_irq = serial_status_register.done && serial_control_register.tx_done_irq_enable;

	// Last data bit index from character length
	assign last_bit = serial_control_register.char7 ? `SMT_LAST_BIT7 : `SMT_LAST_BIT8;

	// Bit-rate timebase, held at zero while idle so a start bit is full length
	smt_baud smt_baud_i (
		.pclk(pclk),
		.presetn(presetn),
		.restart(st == smt_pkg::SMT_IDLE),
		.divisor(baud_div),
		.tick(tick)
	);

	// Register file next values: software writes, then hardware sets
	always_comb begin
		next_hold = tx_holding_register;
		next_stat = serial_status_register;
		next_ctrl = serial_control_register;
		next_baud = baud_div;
		next_prdata = prdata;
		if (wr_acc) begin
			if (reg_hit(paddr, `SMT_OFF_HOLD)) begin
				next_hold = pwdata[7:0];
			end
			if (reg_hit(paddr, `SMT_OFF_STAT)) begin
				if (!pwdata[`SMT_ST_EMPTY]) begin
					next_stat.empty = 1'b0;
					// Fresh data also means the line is no longer finished
					next_stat.done = 1'b0;
				end
				next_stat.mpb = pwdata[`SMT_ST_MPB];
			end
			if (reg_hit(paddr, `SMT_OFF_CTRL)) begin
				next_ctrl = pwdata[4:0];
			end
			if (reg_hit(paddr, `SMT_OFF_BAUD)) begin
				next_baud = pwdata[15:0];
			end
		end
		if (load) begin
			next_stat.empty = 1'b1;
		end
		if (done_set) begin
			next_stat.done = 1'b1;
		end
		// Read data captured in setup so it stands through the access phase
		if (rd_setup) begin
			next_prdata = 32'h0000_0000;
			if (reg_hit(paddr, `SMT_OFF_HOLD)) begin
				next_prdata[7:0] = tx_holding_register;
			end
			if (reg_hit(paddr, `SMT_OFF_STAT)) begin
				next_prdata[2:0] = serial_status_register;
			end
			if (reg_hit(paddr, `SMT_OFF_CTRL)) begin
				next_prdata[4:0] = serial_control_register;
			end
			if (reg_hit(paddr, `SMT_OFF_BAUD)) begin
				next_prdata[15:0] = baud_div;
			end
		end
	end

	// Register file flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_holding_register <= `SMT_RST_HOLD;
			serial_status_register <= {1'b0, `SMT_RST_FLAG, `SMT_RST_FLAG};
			serial_control_register <= `SMT_RST_CTRL;
			baud_div <= `SMT_RST_BAUD;
			prdata <= 32'h0000_0000;
		end else begin
			tx_holding_register <= next_hold;
			serial_status_register <= next_stat;
			serial_control_register <= next_ctrl;
			baud_div <= next_baud;
			prdata <= next_prdata;
		end
	end

	// Frame sequencer next values; every step except the load from idle and the illegal-code recovery waits for the bit tick
	always_comb begin
		next_st = st;
		next_sh = tx_shift_register;
		next_bcnt = bcnt;
		next_chain = chain;
		load = 1'b0;
		done_set = 1'b0;
		unique case (st)
			smt_pkg::SMT_IDLE: begin
				if (serial_control_register.en && !serial_status_register.empty) begin
					load = 1'b1;
					next_sh = tx_holding_register;
					next_st = smt_pkg::SMT_START;
				end
			end
			smt_pkg::SMT_START: begin
				if (tick) begin
					next_bcnt = 3'h0;
					next_st = smt_pkg::SMT_DATA;
				end
			end
			smt_pkg::SMT_DATA: begin
				if (tick) begin
					next_sh = {1'b0, tx_shift_register[7:1]};
					if (bcnt == last_bit) begin
						next_st = smt_pkg::SMT_MPB;
					end else begin
						next_bcnt = bcnt + 3'h1;
					end
				end
			end
			smt_pkg::SMT_MPB: begin
				if (tick) begin
					next_st = smt_pkg::SMT_STOP1;
					if (!serial_status_register.empty) begin
						load = 1'b1;
						next_sh = tx_holding_register;
						next_chain = 1'b1;
					end else begin
						done_set = 1'b1;
						next_chain = 1'b0;
					end
				end
			end
			smt_pkg::SMT_STOP1: begin
				if (tick) begin
					if (serial_control_register.stop2) begin
						next_st = smt_pkg::SMT_STOP2;
					end else begin
						next_st = chain ? smt_pkg::SMT_START : smt_pkg::SMT_IDLE;
					end
				end
			end
			smt_pkg::SMT_STOP2: begin
				if (tick) begin
					next_st = chain ? smt_pkg::SMT_START : smt_pkg::SMT_IDLE;
				end
			end
			default: begin
				// Illegal code recovers to mark state
				next_st = smt_pkg::SMT_IDLE;
			end
		endcase
	end

	// Line level that goes with the next state, so txd and state move together
	always_comb begin
		unique case (next_st)
			smt_pkg::SMT_START: next_txd = 1'b0;
			smt_pkg::SMT_DATA: next_txd = next_sh[0];
			smt_pkg::SMT_MPB: next_txd = next_stat.mpb;
			default: next_txd = 1'b1;
		endcase
	end

	// Sequencer flops; line idles high out of reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= smt_pkg::SMT_IDLE;
			tx_shift_register <= 8'h00;
			bcnt <= 3'h0;
			chain <= 1'b0;
			txd <= 1'b1;
		end else begin
			st <= next_st;
			tx_shift_register <= next_sh;
			bcnt <= next_bcnt;
			chain <= next_chain;
			txd <= next_txd;
		end
	end

	// Checks on the transmitter
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Load from idle
	sequence s_idle_load;
		st == smt_pkg::SMT_IDLE && serial_control_register.en && !serial_status_register.empty;
	endsequence

	// Start bit begins with empty flag raised
	sequence s_start_begins;
		st == smt_pkg::SMT_START && serial_status_register.empty && !txd;
	endsequence

	AST_LOAD_START: assert property (s_idle_load |=> s_start_begins)
		else $error("load did not start a frame");

	AST_IDLE_MARK: assert property (st == smt_pkg::SMT_IDLE |-> txd)
		else $error("line not high while idle");

	AST_START_LOW: assert property (st == smt_pkg::SMT_START |-> !txd)
		else $error("start bit not low");

	AST_FIRST_LSB: assert property ((st == smt_pkg::SMT_START && tick) |=>
		(st == smt_pkg::SMT_DATA && txd == $past(tx_shift_register[0])))
		else $error("first data bit not the LSB");

	AST_MPB_LEVEL: assert property (st == smt_pkg::SMT_MPB |-> txd == serial_status_register.mpb)
		else $error("mp bit level wrong");

	AST_STOP_HIGH: assert property ((st == smt_pkg::SMT_STOP1 || st == smt_pkg::SMT_STOP2) |-> txd)
		else $error("stop bit not high");

	AST_CHAIN: assert property ((st == smt_pkg::SMT_MPB && tick && !serial_status_register.empty)
		|=> (serial_status_register.empty && chain))
		else $error("waiting data not loaded at stop");

	AST_DONE: assert property ((st == smt_pkg::SMT_MPB && tick && serial_status_register.empty)
		|=> (serial_status_register.done && !chain))
		else $error("done flag not set at stop");

	AST_EMPTY_IRQ: assert property ($rose(serial_status_register.empty) &&
		serial_control_register.tx_empty_irq_enable |-> tx_empty_irq)
		else $error("empty request missing");

	AST_DONE_IRQ: assert property ($rose(serial_status_register.done) &&
		serial_control_register.tx_done_irq_enable |-> tx_done_irq)
		else $error("done request missing");

	AST_BIT_HOLD: assert property ((st != smt_pkg::SMT_IDLE && !tick) |=> st == $past(st))
		else $error("state moved without a bit tick");

endmodule
`default_nettype wire

/* File: common/smt_defs.svh */
// Register map, field positions, reset values and counts for the serial transmitter
`ifndef SMT_DEFS_SVH
`define SMT_DEFS_SVH

// Byte offsets of the registers on the bus
`define SMT_OFF_HOLD 12'h000
`define SMT_OFF_STAT 12'h004
`define SMT_OFF_CTRL 12'h008
`define SMT_OFF_BAUD 12'h00C

// Status register field positions
`define SMT_ST_EMPTY 0
`define SMT_ST_DONE 1
`define SMT_ST_MPB 2

// Control register field positions
`define SMT_CT_EN 0
`define SMT_CT_TIE 1
`define SMT_CT_TX_DONE_IRQ_ENABLE 2
`define SMT_CT_CHAR7 3
`define SMT_CT_STOP2 4

// Reset values
`define SMT_RST_HOLD 8'hFF
`define SMT_RST_FLAG 1'b1
`define SMT_RST_BAUD 16'h0363
`define SMT_RST_CTRL 5'h00

// Index of the last data bit for 7-bit and 8-bit characters
`define SMT_LAST_BIT7 3'h6
`define SMT_LAST_BIT8 3'h7

`endif

/* File: common/smt_pkg.sv */
// Types shared by the serial transmitter design files
package smt_pkg;

	// Frame sequencer states
	typedef enum logic [2:0] {
		SMT_IDLE,
		SMT_START,
		SMT_DATA,
		SMT_MPB,
		SMT_STOP1,
		SMT_STOP2
	} smt_state_t;

	// Software control bits, packed in register order (bit 0 last)
	typedef struct packed {
		logic stop2;
		logic char7;
		logic tx_done_irq_enable;
		logic tx_empty_irq_enable;
		logic en;
	} smt_ctrl_t;

	// Status bits, packed in register order (bit 0 last)
	typedef struct packed {
		logic mpb;
		logic done;
		logic empty;
	} smt_stat_t;

endpackage

/* File: verilog/smt_baud.sv */
// Bit-rate timebase: one-cycle tick every divisor+1 clocks
`timescale 1ns/1ns
`default_nettype none

module smt_baud (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Control
	input wire logic restart,
	input wire logic [15:0] divisor,
	// Bit period tick
	output logic tick
);

	// Cycle counter within one bit period
	logic [15:0] cnt;
	logic [15:0] next_cnt;

	// End of bit period reached
	assign tick = !restart && (cnt == divisor);

	// Next count: hold at zero while restarted, wrap at the tick
	always_comb begin
		next_cnt = cnt + 16'h0001;
		if (restart || tick) begin
			next_cnt = 16'h0000;
		end
	end

	// Register the count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 16'h0000;
		end else begin
			cnt <= next_cnt;
		end
	end

endmodule
`default_nettype wire

/* File: test/smt_rx_model.sv */
// Behavioural remote receiver that decodes frames from the serial line
`timescale 1ns/1ns
`default_nettype none

module smt_rx_model (
	// Clock and line
	input wire logic pclk,
	input wire logic txd,
	// Frame shape and bit period in clocks
	input wire logic [31:0] bit_len,
	input wire logic char7,
	input wire logic stop2,
	// Decoded results
	output var logic [7:0] rx_data,
	output var logic rx_mpb,
	output var logic rx_err,
	output var logic [31:0] rx_n,
	output var logic [31:0] rx_gap
);
	// Work variables of the decoder
	time t_last;
	logic [7:0] d;
	logic m;
	integer i;

	// Sampling on the falling edge keeps clear of the line's launch edge
	initial begin
		rx_data = 8'h00;
		rx_mpb = 1'b0;
		rx_err = 1'b0;
		rx_n = 0;
		rx_gap = 0;
		t_last = 0;
		forever begin
			@(negedge pclk);
			if (txd === 1'b0) begin
				rx_gap = 32'((($time - t_last) + 5) / 10);
				t_last = $time;
				// start bit still low at mid-bit
				repeat (bit_len / 2) @(negedge pclk);
				if (txd !== 1'b0) rx_err = 1'b1;
				d = 8'h00;
				// LSB first, seven or eight bits
				for (i = 0; i < (char7 ? 7 : 8); i++) begin
					repeat (bit_len) @(negedge pclk);
					d[i] = txd;
				end
				repeat (bit_len) @(negedge pclk);
				m = txd;
				for (i = 0; i < (stop2 ? 2 : 1); i++) begin
					repeat (bit_len) @(negedge pclk);
					if (txd !== 1'b1) rx_err = 1'b1;
				end
				rx_data = d;
				rx_mpb = m;
				rx_n = rx_n + 1;
			end
		end
	end
endmodule

`default_nettype wire

/* File: test/async_mp_serial_transmitter_tb.sv */
// Self-checking bench for the serial transmitter over APB
`timescale 1ns/1ns
`default_nettype none
`include "smt_defs.svh"

module async_mp_serial_transmitter_tb;
	// Design connections
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, txd;
	logic tx_empty_irq, tx_done_irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic e, char7, stop2;
	// Receiver results
	logic [7:0] rx_data;
	logic rx_mpb, rx_err;
	logic [31:0] rx_n, rx_gap;
	// Counters and case table
	integer miscompares, n_compared, cyc, k, base;
	logic [7:0] dat [4] = '{8'h5A, 8'hC3, 8'h81, 8'h7E};
	logic [3:0] mpv = 4'b0101;

	smt_tx smt_tx_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .txd(txd), .tx_empty_irq(tx_empty_irq),
		.tx_done_irq(tx_done_irq));
	smt_rx_model smt_rx_model_i (.pclk(pclk), .txd(txd), .bit_len(32'd4), .char7(char7),
		.stop2(stop2), .rx_data(rx_data), .rx_mpb(rx_mpb), .rx_err(rx_err), .rx_n(rx_n),
		.rx_gap(rx_gap));

	// 100 MHz clock
	always #5 pclk = ~pclk;

	// One APB transfer; waits on pready, only the hang guard ends a stuck wait
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Compare and count
	task chk(input logic [31:0] g, input logic [31:0] x);
		n_compared++;
		if (g !== x) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask

	// Bounded wait for a frame count
	task wait_rx(input integer target);
		integer n;
		n = 0;
		while (rx_n < target && n < 2000) begin
			@(posedge pclk);
			n++;
		end
		chk(rx_n, target);
	endtask

	// Verdict and end of run
	task finish_test;
		$display("compared %0d, miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Hang guard; the whole run needs well under this
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares++;
			finish_test;
		end
	end

	// Main sequence
	initial begin
		pclk = 0;
		presetn = 0;
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 0;
		pwdata = 0;
		char7 = 0;
		stop2 = 0;
		cyc = 0;
		miscompares = 0;
		n_compared = 0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		// Reset values and an unmapped place
		apb(0, `SMT_OFF_HOLD, 0);
		chk(q, 32'h0000_00FF);
		apb(0, `SMT_OFF_STAT, 0);
		chk(q, 32'h0000_0003);
		apb(0, `SMT_OFF_BAUD, 0);
		chk(q, 32'h0000_0363);
		apb(0, 12'h010, 0);
		chk({q[31:1], e}, 32'h0000_0001);
		@(negedge pclk);
		chk({30'h0, pready, txd}, 32'h0000_0003);
		chk({30'h0, tx_empty_irq, tx_done_irq}, 32'h0000_0000);
		// Disabled: data waits, line stays in mark
		apb(1, `SMT_OFF_BAUD, 32'h0000_0003);
		apb(1, `SMT_OFF_HOLD, 32'h0000_0055);
		apb(1, `SMT_OFF_STAT, 32'h0000_0000);
		repeat (40) @(posedge pclk);
		apb(0, `SMT_OFF_STAT, 0);
		chk(q, 32'h0000_0000);
		chk(rx_n, 0);
		apb(1, `SMT_OFF_CTRL, 32'h0000_0007);
		apb(0, `SMT_OFF_CTRL, 0);
		chk(q, 32'h0000_0007);
		wait_rx(1);
		chk({24'h0, rx_data}, 32'h0000_0055);
		// Every char length and stop length, both mp levels
		for (k = 0; k < 4; k++) begin
			char7 = k[0];
			stop2 = k[1];
			apb(1, `SMT_OFF_CTRL, {27'h0, k[1], k[0], 3'b111});
			apb(1, `SMT_OFF_HOLD, {24'h0, dat[k]});
			apb(1, `SMT_OFF_STAT, {29'h0, mpv[k], 2'b00});
			wait_rx(k + 2);
			chk({24'h0, rx_data}, {24'h0, dat[k] & (k[0] ? 8'h7F : 8'hFF)});
			chk({31'h0, rx_mpb}, {31'h0, mpv[k]});
			chk({31'h0, rx_err}, 32'h0000_0000);
			@(negedge pclk);
			chk({30'h0, tx_empty_irq, tx_done_irq}, 32'h0000_0003);
			apb(0, `SMT_OFF_STAT, 0);
			chk(q, {29'h0, mpv[k], 2'b11});
		end
		// Chained frames: second load during first frame
		char7 = 0;
		stop2 = 0;
		base = rx_n;
		apb(1, `SMT_OFF_CTRL, 32'h0000_0007);
		apb(1, `SMT_OFF_HOLD, 32'h0000_0096);
		apb(1, `SMT_OFF_STAT, 32'h0000_0000);
		apb(0, `SMT_OFF_STAT, 0);
		chk(q, 32'h0000_0001);
		apb(1, `SMT_OFF_HOLD, 32'h0000_0069);
		apb(1, `SMT_OFF_STAT, 32'h0000_0000);
		wait_rx(base + 1);
		chk({24'h0, rx_data}, 32'h0000_0096);
		wait_rx(base + 2);
		chk({24'h0, rx_data}, 32'h0000_0069);
		chk(rx_gap, 32'd44);
		chk({31'h0, rx_err}, 32'h0000_0000);
		finish_test;
	end
endmodule

`default_nettype wire
